// >>> hbr_bridge_ctrl.sv
// H-bridge direction decode, PWM voltage regulator and gate drive
// What this block does
// - Direction bits pick coast, reverse, forward, brake
// - Both bits zero: drivers off, low power
// - Both bits zero clears latched current fault
// - Start in low-power shutdown until bits written
// - Entering drive from brake/standby restarts duty zero
// - Duty ramps gradually; full ramp within 12 ms
// - Quarter of averaged output compared with setpoint
// - Below setpoint raise duty, above lower it
// - On time drives winding in selected direction
// - Setpoint above supply: full duty, no regulation
// - Off time turns both high sides on
// - Setpoint converter follows written setpoint field
// - Fault declared after condition persists 275 ms
`timescale 1ns/100ps
`default_nettype none
module hbr_bridge_ctrl #(
  parameter int unsigned RAMP_FULL_CYC = hbr_pkg::RAMP_FULL_CYC,
  parameter int unsigned DEGLITCH_CYC = hbr_pkg::FAULT_DEGLITCH_CYC,
  parameter int unsigned PERIOD_CYC = hbr_pkg::PWM_PERIOD_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ctlWrite,
  input wire logic dirCtlA,
  input wire logic dirCtlB,
  input wire logic [hbr_pkg::SET_W-1:0] voltageSetpoint,
  input wire logic [hbr_pkg::LEVEL_W-1:0] outDiffAvg,
  input wire logic [hbr_pkg::LEVEL_W-1:0] supplyLevel,
  input wire logic overLimit,
  output logic bridgeOutAHigh,
  output logic bridgeOutALow,
  output logic bridgeOutBHigh,
  output logic bridgeOutBLow,
  output logic lowPower,
  output logic fault_n,
  output logic [hbr_pkg::DUTY_W-1:0] dutyNow
);

  // ==========================================================
  // Elaboration checks
  localparam int unsigned RAMP_STEP_CYC = RAMP_FULL_CYC / PERIOD_CYC;

  initial begin
    if (RAMP_STEP_CYC < 1 || RAMP_STEP_CYC >= (1 << 24)) begin
      $error("Ramp time too short for the PWM period");
    end
    if (PERIOD_CYC < 2 || PERIOD_CYC >= (1 << hbr_pkg::DUTY_W)) begin
      $error("PWM period does not fit the duty width");
    end
  end

  localparam logic [hbr_pkg::DUTY_W-1:0] DUTY_FULL = hbr_pkg::DUTY_W'(PERIOD_CYC);
  localparam logic [23:0] STEP_LAST = 24'(RAMP_STEP_CYC - 1);

  // ==========================================================
  // Helpers

  // Setpoint converter, linear in the code
  function automatic logic [hbr_pkg::LEVEL_W-1:0] setLevel(input logic [hbr_pkg::SET_W-1:0] code);
    setLevel = hbr_pkg::LEVEL_W'(code);
  endfunction : setLevel

  function automatic hbr_pkg::hbr_mode_t decodeMode(input logic [1:0] dir);
    unique case (dir)
      hbr_pkg::DIR_REV: decodeMode = hbr_pkg::MODE_REV;
      hbr_pkg::DIR_FWD: decodeMode = hbr_pkg::MODE_FWD;
      hbr_pkg::DIR_BRAKE: decodeMode = hbr_pkg::MODE_BRAKE;
      default: decodeMode = hbr_pkg::MODE_SLEEP;
    endcase
  endfunction : decodeMode

  // ==========================================================
  // Sub-blocks
  hbr_ctl_if ctl ();

  hbr_pwm_timer #(
    .PERIOD_CYC(PERIOD_CYC)
  ) u_pwm (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(ctl.pwm)
  );

  hbr_fault_filter #(
    .DEGLITCH_CYC(DEGLITCH_CYC)
  ) u_fault (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(ctl.flt)
  );

  // ==========================================================
  // Written control state
  hbr_pkg::hbr_mode_t mode_q;
  hbr_pkg::hbr_mode_t mode_d;
  logic [hbr_pkg::SET_W-1:0] set_q;

  assign mode_d = ctlWrite ? decodeMode({dirCtlA, dirCtlB}) : mode_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= hbr_pkg::MODE_SLEEP;
      set_q <= hbr_pkg::SET_RESET;
    end else begin
      mode_q <= mode_d;
      if (ctlWrite) begin
        set_q <= voltageSetpoint;
      end
    end
  end

  wire driving = (mode_q == hbr_pkg::MODE_FWD) || (mode_q == hbr_pkg::MODE_REV);
  wire idleBefore = (mode_q == hbr_pkg::MODE_SLEEP) || (mode_q == hbr_pkg::MODE_BRAKE);
  wire nextDriving = (mode_d == hbr_pkg::MODE_FWD) || (mode_d == hbr_pkg::MODE_REV);
  wire restartRamp = idleBefore && nextDriving;

  // Standby clears the latch; a trip in the same cycle still wins
  assign ctl.faultClear = (mode_q == hbr_pkg::MODE_SLEEP);
  assign ctl.overLimitRaw = overLimit;
  assign ctl.bridgeActive = driving || (mode_q == hbr_pkg::MODE_BRAKE);

  // ==========================================================
  // Regulator compare
  wire [hbr_pkg::LEVEL_W-1:0] target = setLevel(set_q);
  wire [hbr_pkg::LEVEL_W-1:0] scaledAvg = outDiffAvg >> 2;
  wire lowOut = scaledAvg < target;
  wire highOut = scaledAvg > target;
  wire [hbr_pkg::LEVEL_W+1:0] targetX4 = {target, 2'b00};
  // Setpoint cannot be reached: regulation is pointless
  wire overSupply = targetX4 > {2'b00, supplyLevel};

  // ==========================================================
  // Ramp pacing, one duty step per tick
  logic [23:0] step_q;
  wire stepTick = (step_q == STEP_LAST);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      step_q <= '0;
    end else begin
      step_q <= (stepTick || restartRamp || !driving) ? '0 : step_q + 1'b1;
    end
  end

  // ==========================================================
  // Duty regulator
  logic [hbr_pkg::DUTY_W-1:0] duty_q;
  logic [hbr_pkg::DUTY_W-1:0] duty_d;
  wire dutyAtFull = (duty_q >= DUTY_FULL);
  wire dutyAtZero = (duty_q == '0);
  wire [hbr_pkg::DUTY_W-1:0] dutyUp = dutyAtFull ? DUTY_FULL : duty_q + 1'b1;
  wire [hbr_pkg::DUTY_W-1:0] dutyDown = dutyAtZero ? duty_q : duty_q - 1'b1;

  // Even full duty is reached by ramping, so inrush stays limited
  always_comb begin
    duty_d = duty_q;
    if (restartRamp || !driving) begin
      duty_d = '0;
    end else if (stepTick) begin
      if (overSupply) begin
        duty_d = dutyUp;
      end else if (lowOut) begin
        duty_d = dutyUp;
      end else if (highOut) begin
        duty_d = dutyDown;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      duty_q <= '0;
    end else begin
      duty_q <= duty_d;
    end
  end

  assign ctl.duty = duty_q;

  // ==========================================================
  // Stale-pulse guard
  // The timer holds the old duty until its period ends, so on-time waits for a fresh sample
  logic fresh_q;
  wire onTime = ctl.pwmOn && !fresh_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fresh_q <= 1'b1;
    end else if (restartRamp || !driving) begin
      fresh_q <= 1'b1;
    end else if (ctl.periodEnd) begin
      fresh_q <= 1'b0;
    end
  end

  // ==========================================================
  // Gate decode {aHigh, aLow, bHigh, bLow}
  logic [3:0] gate;
  wire blocked = ctl.faultLatched;

  // Fault turns the bridge off; no shoot-through pair is ever chosen
  always_comb begin
    gate = 4'h0;
    unique case (mode_q)
      hbr_pkg::MODE_SLEEP: begin
        gate = 4'h0;
      end
      hbr_pkg::MODE_BRAKE: begin
        gate = 4'ha;
      end
      hbr_pkg::MODE_FWD: begin
        gate = onTime ? 4'h9 : 4'ha;
      end
      hbr_pkg::MODE_REV: begin
        gate = onTime ? 4'h6 : 4'ha;
      end
    endcase
    if (blocked) begin
      gate = 4'h0;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bridgeOutAHigh <= 1'b0;
      bridgeOutALow <= 1'b0;
      bridgeOutBHigh <= 1'b0;
      bridgeOutBLow <= 1'b0;
      lowPower <= 1'b1;
      fault_n <= 1'b1;
      dutyNow <= '0;
    end else begin
      bridgeOutAHigh <= gate[3];
      bridgeOutALow <= gate[2];
      bridgeOutBHigh <= gate[1];
      bridgeOutBLow <= gate[0];
      lowPower <= (mode_q == hbr_pkg::MODE_SLEEP);
      fault_n <= !ctl.faultLatched;
      dutyNow <= duty_q;
    end
  end

endmodule : hbr_bridge_ctrl
`default_nettype wire

// >>> hbr_pkg.sv
// Shared constants for the H-bridge voltage-control block
package hbr_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PWM_FREQ_HZ = 44_500;
  // Longest period that still meets the switching rate
  localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int unsigned RAMP_FULL_NS = 12_000_000;
  localparam int unsigned RAMP_FULL_CYC = RAMP_FULL_NS / CLK_PERIOD_NS;
  localparam int unsigned FAULT_DEGLITCH_MS = 275;
  localparam int unsigned FAULT_DEGLITCH_CYC = FAULT_DEGLITCH_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Widths and reset values
  localparam int unsigned DUTY_W = 12;
  localparam int unsigned SET_W = 6;
  localparam int unsigned LEVEL_W = 10;
  localparam logic [1:0] DIR_RESET = 2'h0;
  localparam logic [SET_W-1:0] SET_RESET = 6'h00;

  // ==========================================================
  // Bridge modes, one-hot
  typedef enum logic [3:0] {
    MODE_SLEEP = 4'h1,
    MODE_REV = 4'h2,
    MODE_FWD = 4'h4,
    MODE_BRAKE = 4'h8
  } hbr_mode_t;

  // Direction bit pairs {a, b}
  localparam logic [1:0] DIR_COAST = 2'h0;
  localparam logic [1:0] DIR_REV = 2'h1;
  localparam logic [1:0] DIR_FWD = 2'h2;
  localparam logic [1:0] DIR_BRAKE = 2'h3;

endpackage : hbr_pkg

// >>> hbr_ctl_if.sv
// Carrier between the bridge controller, its PWM timer and its fault filter
`timescale 1ns/100ps
`default_nettype none
interface hbr_ctl_if;
  logic [hbr_pkg::DUTY_W-1:0] duty;
  logic pwmOn;
  logic periodEnd;
  logic overLimitRaw;
  logic faultClear;
  logic bridgeActive;
  logic faultLatched;

  modport ctl (
    output duty,
    input pwmOn,
    input periodEnd,
    output overLimitRaw,
    output faultClear,
    output bridgeActive,
    input faultLatched
  );
  modport pwm (
    input duty,
    output pwmOn,
    output periodEnd
  );
  modport flt (
    input overLimitRaw,
    input faultClear,
    input bridgeActive,
    output faultLatched
  );
endinterface : hbr_ctl_if
`default_nettype wire

// >>> hbr_pwm_timer.sv
// Fixed-rate PWM timer with duty sampled at each period start
`timescale 1ns/100ps
`default_nettype none
module hbr_pwm_timer #(
  parameter int unsigned PERIOD_CYC = hbr_pkg::PWM_PERIOD_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  hbr_ctl_if.pwm bus
);

  initial begin
    if (PERIOD_CYC < 2 || PERIOD_CYC >= (1 << hbr_pkg::DUTY_W)) begin
      $error("PWM period does not fit the duty width");
    end
  end

  // ==========================================================
  // Period counter
  localparam logic [hbr_pkg::DUTY_W-1:0] LAST = hbr_pkg::DUTY_W'(PERIOD_CYC - 1);
  logic [hbr_pkg::DUTY_W-1:0] cnt_q;
  logic [hbr_pkg::DUTY_W-1:0] dutyHold_q;
  logic atEnd;

  assign atEnd = (cnt_q == LAST);

  // Duty held for a whole period so one pulse is never cut short
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      dutyHold_q <= '0;
    end else begin
      cnt_q <= atEnd ? '0 : cnt_q + 1'b1;
      if (atEnd) begin
        dutyHold_q <= bus.duty;
      end
    end
  end

  assign bus.pwmOn = (cnt_q < dutyHold_q);
  assign bus.periodEnd = atEnd;

endmodule : hbr_pwm_timer
`default_nettype wire

// >>> hbr_fault_filter.sv
// Current-limit deglitch filter and fault latch
`timescale 1ns/100ps
`default_nettype none
module hbr_fault_filter #(
  parameter int unsigned DEGLITCH_CYC = hbr_pkg::FAULT_DEGLITCH_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  hbr_ctl_if.flt bus
);

  initial begin
    if (DEGLITCH_CYC < 1 || DEGLITCH_CYC >= (1 << 30)) begin
      $error("Deglitch count out of range");
    end
  end

  // ==========================================================
  // Pin synchroniser
  logic sync1_q;
  logic sync2_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= bus.overLimitRaw;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // Persistence counter and latch
  localparam logic [29:0] TRIP = 30'(DEGLITCH_CYC - 1);
  logic [29:0] cnt_q;
  logic latch_q;
  logic counting;
  logic trip;

  assign counting = sync2_q && bus.bridgeActive;
  assign trip = counting && (cnt_q == TRIP);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      latch_q <= 1'b0;
    end else begin
      // Any drop of the condition restarts the interval
      cnt_q <= (counting && !trip) ? cnt_q + 1'b1 : '0;
      // Set wins over a clear in the same cycle
      if (trip) begin
        latch_q <= 1'b1;
      end else if (bus.faultClear) begin
        latch_q <= 1'b0;
      end
    end
  end

  assign bus.faultLatched = latch_q;

endmodule : hbr_fault_filter
`default_nettype wire

// >>> hbr_winding_model.sv
// Motor winding model: averages bridge drive into a level
`timescale 1ns/100ps
`default_nettype none
module hbr_winding_model #(
  parameter int PER = 16,
  parameter int SUP = 100
) (
  input wire logic mclk,
  input wire logic aHi,
  input wire logic aLo,
  input wire logic bHi,
  input wire logic bLo,
  output logic [9:0] avgLevel
);
  int ph;
  int on;
  int acc;
  initial avgLevel = 10'h000;
  // Window of one period; misalignment harmless while duty steady
  always @(posedge mclk) begin
    if ((aHi && bLo) || (aLo && bHi)) on = on + 1;
    ph = ph + 1;
    if (ph == PER) begin
      acc = on * SUP / PER;
      avgLevel <= acc[9:0];
      ph = 0;
      on = 0;
    end
  end
endmodule : hbr_winding_model
`default_nettype wire

// >>> hbr_bridge_monitor.sv
// Port-level checks of the bridge controller
`timescale 1ns/100ps
`default_nettype none
module hbr_bridge_monitor #(
  parameter int unsigned DEGLITCH_CYC = 20
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ctlWrite,
  input wire logic dirCtlA,
  input wire logic dirCtlB,
  input wire logic overLimit,
  input wire logic bridgeOutAHigh,
  input wire logic bridgeOutALow,
  input wire logic bridgeOutBHigh,
  input wire logic bridgeOutBLow,
  input wire logic lowPower,
  input wire logic fault_n,
  input wire logic [hbr_pkg::DUTY_W-1:0] dutyNow
);
  // Slack of two for the input synchroniser
  localparam int DM = DEGLITCH_CYC - 2;
  logic [3:0] g;
  int cnt;
  assign g = {bridgeOutAHigh, bridgeOutALow, bridgeOutBHigh, bridgeOutBLow};
  always_ff @(posedge mclk) cnt <= overLimit ? cnt + 1 : 0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reset_state_a: assert property ($rose(rst_n) |-> lowPower && g == 4'h0 && fault_n && dutyNow == 12'h000)
    else $error("outputs not idle after reset");
  stay_asleep_a: assert property (lowPower && !ctlWrite && !$past(ctlWrite) |=> lowPower)
    else $error("left sleep without a write");
  sleep_off_a: assert property (lowPower |-> g == 4'h0)
    else $error("gates on in sleep");
  go_sleep_a: assert property (ctlWrite && !dirCtlA && !dirCtlB ##1 !ctlWrite |=> lowPower && g == 4'h0)
    else $error("coast write did not sleep");
  leave_sleep_a: assert property (ctlWrite && (dirCtlA || dirCtlB) ##1 !ctlWrite |=> !lowPower)
    else $error("still asleep after drive write");
  brake_a: assert property (ctlWrite && dirCtlA && dirCtlB ##1 !ctlWrite |=> g == (fault_n ? 4'ha : 4'h0))
    else $error("brake gates wrong");
  drive_legal_a: assert property (fault_n && !lowPower |-> g == 4'h9 || g == 4'h6 || g == 4'ha)
    else $error("illegal gate pattern");
  fault_off_a: assert property (!fault_n |-> g == 4'h0)
    else $error("gates on during fault");
  fault_late_a: assert property ($fell(fault_n) |-> $past(cnt, 3) >= DM)
    else $error("fault before deglitch time");
  ramp_zero_a: assert property (ctlWrite && dirCtlA != dirCtlB && lowPower ##1 !ctlWrite
    |=> dutyNow == 12'h000 && g == 4'ha)
    else $error("drive did not start at zero duty");
  duty_step_a: assert property ($changed(dutyNow) |-> dutyNow == 12'h000 || dutyNow == $past(dutyNow) + 12'h001
    || dutyNow == $past(dutyNow) - 12'h001)
    else $error("duty jumped");
  duty_hold_a: assert property ($changed(dutyNow) && dutyNow != 12'h000 |=> $stable(dutyNow) [*8])
    else $error("duty stepped too fast");
endmodule : hbr_bridge_monitor
bind hbr_bridge_ctrl hbr_bridge_monitor #(.DEGLITCH_CYC(DEGLITCH_CYC)) u_mon (.mclk(mclk), .rst_n(rst_n),
  .ctlWrite(ctlWrite), .dirCtlA(dirCtlA), .dirCtlB(dirCtlB), .overLimit(overLimit),
  .bridgeOutAHigh(bridgeOutAHigh), .bridgeOutALow(bridgeOutALow), .bridgeOutBHigh(bridgeOutBHigh),
  .bridgeOutBLow(bridgeOutBLow), .lowPower(lowPower), .fault_n(fault_n), .dutyNow(dutyNow));
`default_nettype wire

// >>> hbr_bridge_ctrl_tb_top.sv
// Self-checking bench for the bridge controller
`timescale 1ns/100ps
`default_nettype none
module hbr_bridge_ctrl_tb_top;
  localparam int DEG = 20;
  localparam logic [11:0] MEXP [4] = '{12'h030, 12'h01a, 12'h01a, 12'h01a};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ctlWrite = 1'b0;
  logic dirCtlA = 1'b0;
  logic dirCtlB = 1'b0;
  logic [5:0] setCode = 6'h00;
  logic overLimit = 1'b0;
  logic [9:0] avg;
  logic aH, aL, bH, bL, lowPower, fault_n;
  logic [11:0] duty;
  wire logic [11:0] st = {6'h00, lowPower, fault_n, aH, aL, bH, bL};
  int failures = 0;
  int samples_checked = 0;
  always #5 mclk = ~mclk;
  // Ramp step of 64 cycles outlasts the model's averaging lag
  hbr_bridge_ctrl #(.RAMP_FULL_CYC(1024), .DEGLITCH_CYC(DEG), .PERIOD_CYC(16)) uut (.mclk(mclk), .rst_n(rst_n),
    .ctlWrite(ctlWrite), .dirCtlA(dirCtlA), .dirCtlB(dirCtlB), .voltageSetpoint(setCode), .outDiffAvg(avg),
    .supplyLevel(10'h064), .overLimit(overLimit), .bridgeOutAHigh(aH), .bridgeOutALow(aL),
    .bridgeOutBHigh(bH), .bridgeOutBLow(bL), .lowPower(lowPower), .fault_n(fault_n), .dutyNow(duty));
  hbr_winding_model #(.PER(16), .SUP(100)) wind (.mclk(mclk), .aHi(aH), .aLo(aL), .bHi(bH), .bLo(bL),
    .avgLevel(avg));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle
  task automatic wr(input logic [1:0] d, input logic [5:0] s);
    @(negedge mclk);
    ctlWrite = 1'b1;
    {dirCtlA, dirCtlB} = d;
    setCode = s;
    @(negedge mclk);
    ctlWrite = 1'b0;
  endtask : wr
  task automatic end_of_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Scenarios
  task automatic t_modes();
    chk(st, 12'h030);
    idle(20);
    chk(st, 12'h030);
    for (int i = 0; i < 4; i++) begin
      wr(i[1:0], 6'h00);
      idle(3);
      chk(st, MEXP[i]);
    end
    wr(2'h2, 6'h1e);
    idle(1300);
    chk(duty, 12'h010);
    chk(st, 12'h019);
    wr(2'h1, 6'h1e);
    idle(5);
    chk(duty, 12'h010);
    chk(st, 12'h016);
    wr(2'h3, 6'h1e);
    idle(3);
    chk(st, 12'h01a);
    wr(2'h2, 6'h1e);
    idle(2);
    chk(duty, 12'h000);
    $display("done modes");
  endtask : t_modes
  task automatic t_reg();
    int on;
    int off;
    on = 0;
    off = 0;
    wr(2'h0, 6'h00);
    wr(2'h2, 6'h0a);
    idle(130);
    chk({11'h000, duty > 12'h003}, 12'h000);
    idle(800);
    chk(duty, 12'h007);
    repeat (16) begin
      @(negedge mclk);
      on += int'(st == 12'h019);
      off += int'(st == 12'h01a);
    end
    chk(12'(on), 12'h007);
    chk(12'(off), 12'h009);
    wr(2'h2, 6'h06);
    idle(600);
    chk(duty, 12'h004);
    $display("done regulation");
  endtask : t_reg
  task automatic t_fault();
    wr(2'h0, 6'h00);
    wr(2'h2, 6'h00);
    idle(3);
    overLimit = 1'b1;
    idle(DEG - 5);
    overLimit = 1'b0;
    idle(DEG + 10);
    chk(st, 12'h01a);
    overLimit = 1'b1;
    idle(DEG + 8);
    chk(st, 12'h000);
    overLimit = 1'b0;
    wr(2'h3, 6'h00);
    idle(3);
    chk(st, 12'h000);
    wr(2'h0, 6'h00);
    idle(3);
    chk(st, 12'h030);
    wr(2'h2, 6'h00);
    idle(3);
    chk(st, 12'h01a);
    rst_n = 1'b0;
    idle(5);
    rst_n = 1'b1;
    idle(1);
    chk(st, 12'h030);
    $display("done fault");
  endtask : t_fault
  initial begin
    idle(5);
    rst_n = 1'b1;
    idle(1);
    t_modes();
    t_reg();
    t_fault();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    end_of_test();
  end
endmodule : hbr_bridge_ctrl_tb_top
`default_nettype wire
